// [logic/slcr_regs.sv]
`timescale 1ns/1ps
`include "slcr_params.svh"
module slcr_regs #(
  parameter int NUM_CHANNELS = 512
) (
  input wire logic clock,
  input wire logic resetn,
  input wire slcr_pkg::slcr_req_t req,
  output slcr_pkg::slcr_rsp_t rsp,
  input wire slcr_pkg::slcr_chan_wr_t chan_wr,
  input wire logic [8:0] chan_rd_idx,
  output logic [15:0] chan_rd_data,
  input wire logic link_permit,
  input wire slcr_pkg::slcr_cfg_t cfg,
  input wire logic [15:0] link_freq_ref,
  input wire logic [15:0] link_pid_ref,
  output slcr_pkg::slcr_cmd_t cmd
);
  import slcr_pkg::*;

  // the address map is fixed at 512 channels, refused at elaboration
  if (NUM_CHANNELS != 512) begin : g_bad_channels
    $error("slcr_regs: NUM_CHANNELS must be 512");
  end

  // true when addr lies within [lo, hi]
  function automatic logic in_range(input logic [15:0] addr, input logic [15:0] lo,
                                    input logic [15:0] hi);
    in_range = (addr >= lo) && (addr <= hi);
  endfunction

  // channel storage; the core fills the read-only ranges
  logic [15:0] chan_mem [NUM_CHANNELS];
  logic [15:0] ctrl_r; // last value written to the control register
  logic [15:0] ctrl_nxt;
  slcr_fc_t fc_r; // fault clear pattern tracker
  slcr_fc_t fc_nxt;
  slcr_rsp_t rsp_nxt;
  slcr_cmd_t cmd_nxt;
  logic [15:0] chan_rd_nxt;
  logic [15:0] eff; // control word as seen by the drive
  logic [8:0] req_idx; // channel index of a link address
  logic hit_ro; // request falls in a read-only channel range
  logic hit_rw; // request falls in the writable channel range
  logic hit_ctrl; // request addresses the control register
  logic chan_we; // accepted link write to a channel
  logic ctrl_we; // accepted link write to the control register
  logic start_sel;
  logic freq_sel;
  logic pid_sel;
  logic any_blk;

  // address decode
  always_comb begin
    req_idx = 9'(req.addr - `SLCR_LO_FIRST);
    hit_ro = in_range(req.addr, `SLCR_LO_FIRST, `SLCR_LO_LAST)
           | in_range(req.addr, `SLCR_HI_FIRST, `SLCR_HI_LAST);
    hit_rw = in_range(req.addr, `SLCR_RW_FIRST, `SLCR_RW_LAST);
    hit_ctrl = (req.addr == `SLCR_CTRL_ADDR);
    chan_we = req.valid && req.write && hit_rw;
    ctrl_we = req.valid && req.write && hit_ctrl;
  end

  // answer: data for reads, exception for refused or unmapped access
  always_comb begin
    rsp_nxt = '0;
    rsp_nxt.valid = req.valid;
    if (req.valid) begin
      if (hit_ctrl) begin
        rsp_nxt.rdata = req.write ? req.wdata : ctrl_r;
      end else if (hit_rw) begin
        rsp_nxt.rdata = req.write ? req.wdata : chan_mem[req_idx];
      end else if (hit_ro && !req.write) begin
        rsp_nxt.rdata = chan_mem[req_idx];
      end else begin
        // read-only write or unmapped address: nothing stored
        rsp_nxt.exception = 1'b1;
      end
    end
  end

  // the control word is stored whatever the permission, so reads echo it
  always_comb begin
    ctrl_nxt = ctrl_we ? req.wdata : ctrl_r;
  end

  // fault clear pattern: only writes under permission advance it
  always_comb begin
    fc_nxt = fc_r;
    if (ctrl_we && link_permit) begin
      unique case (fc_r)
        FC_WAIT_LOW: begin
          if (!req.wdata[`SLCR_B_FCLR]) fc_nxt = FC_SAW_LOW;
        end
        FC_SAW_LOW: begin
          if (req.wdata[`SLCR_B_FCLR]) fc_nxt = FC_SAW_HIGH;
        end
        FC_SAW_HIGH: begin
          if (!req.wdata[`SLCR_B_FCLR]) fc_nxt = FC_SAW_LOW;
        end
      endcase
    end
  end

  // drive command; unused bits never reach this logic
  always_comb begin
    eff = link_permit ? ctrl_r : 16'h0000;
    start_sel = eff[`SLCR_B_START] | cfg.start_link;
    freq_sel = eff[`SLCR_B_FREQ] | cfg.freq_link;
    pid_sel = eff[`SLCR_B_PID] | cfg.pid_link;
    any_blk = eff[`SLCR_B_BLK_CFG] | eff[`SLCR_B_BLK_RAMP] | eff[`SLCR_B_BLK_COAST];
    cmd_nxt = '0;
    cmd_nxt.start_from_link = start_sel;
    cmd_nxt.freq_from_link = freq_sel;
    cmd_nxt.pid_from_link = pid_sel;
    // without permission a link source reads as stop and zero
    cmd_nxt.run = start_sel ? eff[`SLCR_B_RUN] : cfg.run;
    cmd_nxt.freq = freq_sel ? (link_permit ? link_freq_ref : 16'h0000) : cfg.freq;
    cmd_nxt.pid = pid_sel ? (link_permit ? link_pid_ref : 16'h0000) : cfg.pid;
    // coast is the harshest request, so it wins over ramp and config
    if (eff[`SLCR_B_BLK_COAST]) begin
      cmd_nxt.stop_mode = STOP_COAST;
    end else if (eff[`SLCR_B_BLK_RAMP]) begin
      cmd_nxt.stop_mode = STOP_RAMP;
    end else if (eff[`SLCR_B_BLK_CFG]) begin
      cmd_nxt.stop_mode = STOP_CONFIG;
    end else begin
      cmd_nxt.stop_mode = STOP_NONE;
    end
    if (any_blk) begin
      cmd_nxt.run = 1'b0;
      cmd_nxt.blocked = 1'b1;
    end
    cmd_nxt.fault_clear = ctrl_we && link_permit && (fc_r == FC_SAW_HIGH)
                        && !req.wdata[`SLCR_B_FCLR];
  end

  // core read port into channel storage
  always_comb begin
    chan_rd_nxt = chan_mem[chan_rd_idx];
  end

  // control state registers
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      ctrl_r <= `SLCR_CTRL_RST;
      fc_r <= FC_WAIT_LOW;
      rsp <= '0;
      cmd <= '0;
      chan_rd_data <= 16'h0000;
    end else begin
      ctrl_r <= ctrl_nxt;
      fc_r <= fc_nxt;
      rsp <= rsp_nxt;
      cmd <= cmd_nxt;
      chan_rd_data <= chan_rd_nxt;
    end
  end

  // channel storage: link owns the writable range, core the rest
  always_ff @(posedge clock) begin
    if (chan_we) begin
      chan_mem[req_idx] <= req.wdata;
    end
    // a core write into the link range is dropped to avoid a clash
    if (chan_wr.valid && !(chan_wr.idx >= `SLCR_RW_IDX
                           && chan_wr.idx < `SLCR_RW_IDX + `SLCR_RW_COUNT)) begin
      chan_mem[chan_wr.idx] <= chan_wr.data;
    end
  end

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!resetn);

  // three writes of the clear bit
  sequence s_fc_low;
    ctrl_we && link_permit && !req.wdata[`SLCR_B_FCLR];
  endsequence
  sequence s_fc_high;
    ctrl_we && link_permit && req.wdata[`SLCR_B_FCLR];
  endsequence
  // a cycle with no permitted control write, so the tracker holds
  sequence s_fc_idle;
    !(ctrl_we && link_permit);
  endsequence

  a_ro_low_refused: assert property (
    req.valid && req.write && in_range(req.addr, `SLCR_LO_FIRST, `SLCR_LO_LAST)
    |=> rsp.valid && rsp.exception)
    else $error("write to low read-only channel not refused");

  a_rw_chan_store: assert property (
    chan_we |=> rsp.valid && !rsp.exception && chan_mem[$past(req_idx)] == $past(req.wdata))
    else $error("writable channel did not store");

  a_ro_high_refused: assert property (
    req.valid && req.write && in_range(req.addr, `SLCR_HI_FIRST, `SLCR_HI_LAST)
    |=> rsp.exception && chan_mem[$past(req_idx)] == $past(chan_mem[req_idx]))
    else $error("write to high read-only channel not refused");

  // low, high, low with one idle cycle between each must raise fault clear a cycle later, so gaps are fixed
  a_fault_clear_seq: assert property (
    s_fc_low ##1 s_fc_idle ##1 s_fc_high ##1 s_fc_idle ##1 s_fc_low |=> cmd.fault_clear)
    else $error("fault clear pattern not honoured");

  a_fault_clear_cause: assert property (
    cmd.fault_clear |-> $past(fc_r) == FC_SAW_HIGH && $past(ctrl_we))
    else $error("fault clear without pattern");

  a_pid_forced: assert property (
    link_permit && ctrl_r[`SLCR_B_PID] |=> cmd.pid_from_link && cmd.pid == $past(link_pid_ref))
    else $error("pid setpoint not taken from link");

  a_freq_forced: assert property (
    link_permit && (ctrl_r[`SLCR_B_FREQ] || cfg.freq_link)
    |=> cmd.freq == $past(link_freq_ref))
    else $error("frequency setpoint not taken from link");

  a_run_follows: assert property (
    link_permit && ctrl_r[`SLCR_B_START] && !ctrl_r[`SLCR_B_BLK_CFG]
    && !ctrl_r[`SLCR_B_BLK_RAMP] && !ctrl_r[`SLCR_B_BLK_COAST]
    |=> cmd.run == $past(ctrl_r[`SLCR_B_RUN]))
    else $error("run does not follow link bit");

  a_block_stops: assert property (
    link_permit && (ctrl_r[`SLCR_B_BLK_CFG] || ctrl_r[`SLCR_B_BLK_RAMP]
    || ctrl_r[`SLCR_B_BLK_COAST]) |=> !cmd.run && cmd.blocked)
    else $error("blocking bit did not stop drive");

  a_coast_mode: assert property (
    link_permit && ctrl_r[`SLCR_B_BLK_COAST] |=> cmd.stop_mode == STOP_COAST)
    else $error("coast block not reported");

  a_no_permit_stop: assert property (
    !link_permit && cfg.start_link |=> !cmd.run)
    else $error("link start ran without permission");

  a_ctrl_readback: assert property (
    req.valid && !req.write && hit_ctrl |=> rsp.rdata == $past(ctrl_r))
    else $error("control read does not echo last write");

  a_unmapped_exc: assert property (
    req.valid && !hit_ro && !hit_rw && !hit_ctrl |=> rsp.valid && rsp.exception)
    else $error("unmapped address not refused");

  // ramp wins over the configured method but yields to coast
  a_ramp_mode: assert property (
    link_permit && ctrl_r[`SLCR_B_BLK_RAMP] && !ctrl_r[`SLCR_B_BLK_COAST]
    |=> cmd.stop_mode == STOP_RAMP && !cmd.run)
    else $error("ramp block not reported");

  a_config_mode: assert property (
    link_permit && ctrl_r[`SLCR_B_BLK_CFG] && !ctrl_r[`SLCR_B_BLK_RAMP]
    && !ctrl_r[`SLCR_B_BLK_COAST] |=> cmd.stop_mode == STOP_CONFIG && !cmd.run)
    else $error("configured block not reported");

  // forcing a source must hand it to the link
  a_start_forced: assert property (
    link_permit && ctrl_r[`SLCR_B_START] |=> cmd.start_from_link)
    else $error("run source not forced to link");

  a_no_permit_zero: assert property (
    !link_permit && cfg.freq_link |=> cmd.freq == 16'h0000)
    else $error("link setpoint used without permission");

  // without permission the stored word must act as all zero
  a_no_permit_ignored: assert property (
    !link_permit && !cfg.start_link |=> cmd.run == $past(cfg.run) && !cmd.blocked)
    else $error("control word acted without permission");

  a_config_src_kept: assert property (
    !(link_permit && ctrl_r[`SLCR_B_FREQ]) && !cfg.freq_link
    |=> !cmd.freq_from_link && cmd.freq == $past(cfg.freq))
    else $error("configured setpoint not kept");

  // a refused or channel write must leave the control word alone
  a_refused_no_store: assert property (
    req.valid && req.write && !hit_ctrl |=> $stable(ctrl_r))
    else $error("refused write changed the control word");

  // reads of core-owned channels show what the core stored
  a_ro_read_data: assert property (
    req.valid && !req.write && hit_ro
    |=> rsp.valid && !rsp.exception && rsp.rdata == $past(chan_mem[req_idx]))
    else $error("read-only channel read returned wrong data");
endmodule

// [logic/slcr_params.svh]
`ifndef SLCR_PARAMS_SVH
`define SLCR_PARAMS_SVH
// link address map
`define SLCR_LO_FIRST 16'h03e8
`define SLCR_LO_LAST 16'h0567
`define SLCR_RW_FIRST 16'h0568
`define SLCR_RW_LAST 16'h05a7
`define SLCR_HI_FIRST 16'h05a8
`define SLCR_HI_LAST 16'h05e7
`define SLCR_CTRL_ADDR 16'h07d0
// first channel index of the writable range
`define SLCR_RW_IDX 9'h180
// number of channels in the writable range
`define SLCR_RW_COUNT 9'h040
// control register reset value
`define SLCR_CTRL_RST 16'h0000
// control register bit positions
`define SLCR_B_FCLR 1
`define SLCR_B_PID 4
`define SLCR_B_FREQ 5
`define SLCR_B_START 6
`define SLCR_B_BLK_CFG 12
`define SLCR_B_BLK_RAMP 13
`define SLCR_B_BLK_COAST 14
`define SLCR_B_RUN 15
`endif

// [logic/slcr_pkg.sv]
package slcr_pkg;
  // link register request, one cycle wide
  typedef struct packed {
    logic valid;
    logic write;
    logic [15:0] addr;
    logic [15:0] wdata;
  } slcr_req_t;
  // answer to a link request
  typedef struct packed {
    logic valid;
    logic exception;
    logic [15:0] rdata;
  } slcr_rsp_t;
  // channel update from the drive core
  typedef struct packed {
    logic valid;
    logic [8:0] idx;
    logic [15:0] data;
  } slcr_chan_wr_t;
  // configured sources and setpoints from the drive core
  typedef struct packed {
    logic start_link;
    logic freq_link;
    logic pid_link;
    logic run;
    logic [15:0] freq;
    logic [15:0] pid;
  } slcr_cfg_t;
  // how a blocked drive is brought to rest
  typedef enum logic [1:0] {
    STOP_NONE,
    STOP_CONFIG,
    STOP_RAMP,
    STOP_COAST
  } slcr_stop_t;
  // command to the drive core
  typedef struct packed {
    logic run;
    logic blocked;
    slcr_stop_t stop_mode;
    logic start_from_link;
    logic freq_from_link;
    logic pid_from_link;
    logic fault_clear;
    logic [15:0] freq;
    logic [15:0] pid;
  } slcr_cmd_t;
  // progress through the low-high-low fault clear pattern
  typedef enum logic [1:0] {
    FC_WAIT_LOW,
    FC_SAW_LOW,
    FC_SAW_HIGH
  } slcr_fc_t;
endpackage

// [sim/slcr_link_master.sv]
`timescale 1ns/1ps
// link master model: one request at a time, pace set by gap
module slcr_link_master (
  input wire logic clock,
  output slcr_pkg::slcr_req_t req,
  input wire slcr_pkg::slcr_rsp_t rsp
);
  import slcr_pkg::*;
  int gap = 0; // idle cycles before each request, one at the least
  initial begin
    req = '0;
  end
  // held across the taking edge, answer sampled just after it
  task automatic xfer(input logic wr, input logic [15:0] a, input logic [15:0] d,
                      output logic [1:0] st, output logic [15:0] rd);
    // one idle edge at least, so a release and the next request never share a step
    repeat ((gap > 0) ? gap : 1) @(posedge clock);
    #1;
    req = '{valid: 1'b1, write: wr, addr: a, wdata: d};
    @(posedge clock);
    #1;
    // released lines show the inverse so stale values never pass
    req = '{valid: 1'b0, write: ~wr, addr: ~a, wdata: ~d};
    st = {rsp.valid, rsp.exception};
    rd = rsp.rdata;
  endtask
endmodule

// [sim/testbench.sv]
`timescale 1ns/1ps
module testbench;
  import slcr_pkg::*;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  slcr_req_t req;
  slcr_rsp_t rsp;
  slcr_chan_wr_t chan_wr = '0;
  logic [8:0] chan_rd_idx = 9'h000;
  logic [15:0] chan_rd_data;
  logic link_permit = 1'b1;
  slcr_cfg_t cfg = '{1'b0, 1'b0, 1'b0, 1'b1, 16'h0111, 16'h0222};
  logic [15:0] link_freq_ref = 16'h0333;
  logic [15:0] link_pid_ref = 16'h0444;
  slcr_cmd_t cmd;
  int miscompares = 0;
  int checked = 0;
  logic [1:0] st;
  logic [15:0] rd, a, d;
  logic [8:0] idx;
  logic mapped, rw;
  // range edges, then unmapped neighbours
  logic [15:0] addrs [10] = '{16'h03e8, 16'h0567, 16'h0568, 16'h05a7, 16'h05a8,
                              16'h05e7, 16'h03e7, 16'h05e8, 16'h07cf, 16'h07d1};

  // free running clock
  initial begin
    forever #25 clock = ~clock;
  end

  slcr_regs dut (.clock(clock), .resetn(resetn), .req(req), .rsp(rsp), .chan_wr(chan_wr),
    .chan_rd_idx(chan_rd_idx), .chan_rd_data(chan_rd_data), .link_permit(link_permit),
    .cfg(cfg), .link_freq_ref(link_freq_ref), .link_pid_ref(link_pid_ref), .cmd(cmd));
  slcr_link_master master (.clock(clock), .req(req), .rsp(rsp));

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    $display("checks %0d, mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // drive core update port for one edge
  task automatic core_wr(input logic [8:0] i, input logic [15:0] v);
    chan_wr = '{valid: 1'b1, idx: i, data: v};
    @(posedge clock);
    #1;
    chan_wr = '{valid: 1'b0, idx: ~i, data: ~v};
  endtask

  // control write, readback, then command is two cycles old
  task automatic ctl(input logic [15:0] w, input logic [15:0] ef, input logic [3:0] e);
    master.xfer(1'b1, 16'h07d0, w, st, rd);
    master.xfer(1'b0, 16'h07d0, 16'h0000, st, rd);
    check(rd, w);
    check({12'h000, cmd.run, cmd.blocked, cmd.stop_mode}, {12'h000, e});
    check(cmd.freq, ef);
    check({13'h0000, cmd.start_from_link, cmd.freq_from_link, cmd.pid_from_link},
          {13'h0000, (link_permit & w[6]) | cfg.start_link,
           (link_permit & w[5]) | cfg.freq_link, (link_permit & w[4]) | cfg.pid_link});
  endtask

  initial begin
    repeat (8) @(posedge clock);
    #1;
    resetn = 1'b1;
    master.gap = 1;
    for (int i = 0; i < 10; i++) begin
      a = addrs[i];
      idx = 9'(a - 16'h03e8);
      mapped = a >= 16'h03e8 && a <= 16'h05e7;
      rw = a >= 16'h0568 && a <= 16'h05a7;
      d = 16'h5a00 + 16'(i);
      chan_rd_idx = idx;
      if (mapped && !rw) core_wr(idx, ~d);
      master.xfer(1'b1, a, d, st, rd);
      check({14'h0000, st}, {14'h0000, 1'b1, !rw});
      check(rd, rw ? d : 16'h0000);
      // core update to a link-owned channel must be dropped
      if (rw) core_wr(idx, ~d);
      master.xfer(1'b0, a, 16'h0000, st, rd);
      check({14'h0000, st}, {14'h0000, 1'b1, !mapped});
      check(rd, rw ? d : (mapped ? ~d : 16'h0000));
      if (mapped) check(chan_rd_data, rw ? d : ~d);
    end
    $display("test channel map done");
    master.gap = 0;
    ctl(16'h0000, 16'h0111, {1'b1, 1'b0, STOP_NONE});
    check(cmd.pid, 16'h0222);
    ctl(16'h8040, 16'h0111, {1'b1, 1'b0, STOP_NONE});
    ctl(16'h0040, 16'h0111, {1'b0, 1'b0, STOP_NONE});
    ctl(16'h0f8d, 16'h0111, {1'b1, 1'b0, STOP_NONE});
    ctl(16'h0020, 16'h0333, {1'b1, 1'b0, STOP_NONE});
    ctl(16'h0010, 16'h0111, {1'b1, 1'b0, STOP_NONE});
    check(cmd.pid, 16'h0444);
    for (int i = 0; i < 3; i++) begin
      ctl(16'h8040 | (16'h1000 << i), 16'h0111, {1'b0, 1'b1, 2'(i + 1)});
    end
    cfg.freq_link = 1'b1;
    ctl(16'h0000, 16'h0333, {1'b1, 1'b0, STOP_NONE});
    $display("test control bits done");
    link_permit = 1'b0;
    cfg.freq_link = 1'b0;
    ctl(16'hc060, 16'h0111, {1'b1, 1'b0, STOP_NONE});
    cfg.start_link = 1'b1;
    cfg.freq_link = 1'b1;
    ctl(16'h0000, 16'h0000, {1'b0, 1'b0, STOP_NONE});
    cfg.start_link = 1'b0;
    cfg.freq_link = 1'b0;
    link_permit = 1'b1;
    $display("test permission done");
    // low, high, low, each taken two cycles after the one before
    master.xfer(1'b1, 16'h07d0, 16'h0000, st, rd);
    check({15'h0000, cmd.fault_clear}, 16'h0000);
    master.xfer(1'b1, 16'h07d0, 16'h0002, st, rd);
    check({15'h0000, cmd.fault_clear}, 16'h0000);
    master.xfer(1'b1, 16'h07d0, 16'h0000, st, rd);
    check({15'h0000, cmd.fault_clear}, 16'h0001);
    @(posedge clock);
    #1;
    check({15'h0000, cmd.fault_clear}, 16'h0000);
    $display("test fault clear done");
    conclude();
  end

  // hang guard, well past the expected hundred or so cycles
  initial begin
    #(50 * 4000);
    miscompares++;
    conclude();
  end
endmodule
